/* src/stm_pkg.sv */
package stm_pkg;
    // Register byte addresses on APB (one aligned word each)
    localparam logic [11:0] STM_OFF_CTRL0 = 12'h000;
    localparam logic [11:0] STM_OFF_CTRL1 = 12'h004;
    localparam logic [11:0] STM_OFF_CNT_LO = 12'h008;
    localparam logic [11:0] STM_OFF_CNT_HI = 12'h00c;
    localparam logic [11:0] STM_OFF_CMPA_LO = 12'h010;
    localparam logic [11:0] STM_OFF_CMPA_HI = 12'h014;
    localparam logic [11:0] STM_OFF_CMPP = 12'h018;
    // Field positions
    localparam int STM_RUN_BIT = 3;
    localparam int STM_CLR_BIT = 0;
    localparam int STM_SWAP_BIT = 1;
    localparam int STM_INV_BIT = 2;
    localparam int STM_OC_BIT = 3;
    localparam int STM_PF_LSB = 4;
    localparam int STM_MODE_LSB = 6;
    // Reset values, control-0 read mask, P wrap value and counter maximum
    localparam logic [7:0] STM_CTRL0_RST = 8'h00;
    localparam logic [7:0] STM_CTRL1_RST = 8'h00;
    localparam logic [15:0] STM_CNT_RST = 16'h0000;
    localparam logic [15:0] STM_CMPA_RST = 16'h0000;
    localparam logic [7:0] STM_CMPP_RST = 8'h00;
    localparam logic [7:0] STM_CTRL0_MASK = 8'hf8;
    localparam logic [7:0] STM_CMPP_WRAP = 8'h00;
    localparam logic [15:0] STM_CNT_MAX = 16'hffff;
    // Operating modes
    localparam logic [1:0] STM_MODE_CMP = 2'h0;
    localparam logic [1:0] STM_MODE_CAP = 2'h1;
    localparam logic [1:0] STM_MODE_PWM = 2'h2;
    localparam logic [1:0] STM_MODE_TC = 2'h3;
    // Pin functions
    localparam logic [1:0] STM_PF_0 = 2'h0;
    localparam logic [1:0] STM_PF_1 = 2'h1;
    localparam logic [1:0] STM_PF_2 = 2'h2;
    localparam logic [1:0] STM_PF_3 = 2'h3;

    typedef struct packed {
        logic [1:0] mode_select;
        logic [1:0] pin_function_select;
        logic output_level_control;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_select;
    } stm_ctrl1_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } stm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } stm_apb_rsp_t;
endpackage : stm_pkg

/* src/stm_timer.sv */
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - Run rising edge zeroes counter; falling holds
// - Run low stops counting, timer off
// - Run rising edge restores initial output level in compare mode
// - Mode field selects four operating modes
// - Timer/counter mode ignores output control bits
// - Compare mode: A match none/low/high/toggle
// - PWM mode: inactive/active/PWM/single pulse
// - Capture mode: rising/falling/both/disabled edge
// - Match to initial level shows no change
// - Output control: initial or active level
// - Invert bit inverts output pin
// - Swap bit exchanges period and duty roles
// - Clear on A match or P/overflow
// - Overflow clear only when P is zero
// - Clear select ignored in PWM/capture modes
// - Counter readable as two zero-reset bytes
// - Compare A 16-bit, two zero-reset bytes
// - P matches counter high byte with low byte zero
// - Low three control-0 bits read zero
// - Low bytes pass through shared byte buffer
module stm_timer
    import stm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire stm_pkg::stm_apb_req_t apb_req,
    output stm_pkg::stm_apb_rsp_t apb_rsp,
    input wire logic count_tick,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic [15:0] capture_value,
    output logic capture_event,
    output logic match_a_event,
    output logic match_p_event
);
    import stm_pkg::*;

    typedef enum logic [1:0] {
        STM_SP_IDLE = 2'b01,
        STM_SP_ACTIVE = 2'b10
    } stm_sp_state_t;

    logic [7:0] ctrl0_reg;
    stm_ctrl1_t ctrl1_reg;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] cmpa_reg;
    logic [7:0] cmpp_reg;
    logic [7:0] buf_reg;
    logic run_d_reg;
    logic out_reg, out_next;
    logic [2:0] cap_sync_reg;
    logic cap_level_reg;
    stm_sp_state_t sp_reg, sp_next;
    logic [31:0] rdata_reg;

    function automatic logic sel_addr(input logic [11:0] a, input logic [11:0] off);
        sel_addr = (a == off);
    endfunction : sel_addr

    // APB decode: zero-wait answer, pslverr on unmapped address
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic setup = apb_req.psel && !apb_req.penable;
    wire logic wr = acc && apb_req.pwrite;
    wire logic rd = acc && !apb_req.pwrite;
    wire logic [11:0] addr = apb_req.paddr;
    wire logic [7:0] wbyte = apb_req.pwdata[7:0];
    wire logic hit = sel_addr(addr, STM_OFF_CTRL0) || sel_addr(addr, STM_OFF_CTRL1)
        || sel_addr(addr, STM_OFF_CNT_LO) || sel_addr(addr, STM_OFF_CNT_HI)
        || sel_addr(addr, STM_OFF_CMPA_LO) || sel_addr(addr, STM_OFF_CMPA_HI)
        || sel_addr(addr, STM_OFF_CMPP);

    wire logic run = ctrl0_reg[STM_RUN_BIT];
    wire logic run_rise = run && !run_d_reg;
    wire logic [1:0] mode = ctrl1_reg.mode_select;
    wire logic [1:0] pf = ctrl1_reg.pin_function_select;
    wire logic oc = ctrl1_reg.output_level_control;
    wire logic is_cmp = (mode == STM_MODE_CMP);
    wire logic is_cap = (mode == STM_MODE_CAP);
    wire logic is_pwm = (mode == STM_MODE_PWM);
    wire logic is_tc = (mode == STM_MODE_TC);

    wire logic tick = run && count_tick;
    wire logic [15:0] cnt_inc = cnt_reg + 16'h0001;
    // A match is the tick on which the count reaches the compare value, so the
    // clear lands in that same tick and P at n gives n*256 ticks exactly
    wire logic match_a = tick && (cnt_inc == cmpa_reg);
    wire logic p_hit = tick && (cnt_inc[15:8] == cmpp_reg) && (cnt_inc[7:0] == 8'h00)
        && (cmpp_reg != STM_CMPP_WRAP);
    wire logic ovf = tick && (cnt_reg == STM_CNT_MAX);
    wire logic match_p = p_hit || (ovf && (cmpp_reg == STM_CMPP_WRAP));
    wire logic p_is_period = !ctrl1_reg.duty_period_swap;

    logic clear_now;
    always_comb
    begin
        if (is_pwm)
        begin
            clear_now = p_is_period ? match_p : match_a;
        end
        else if (is_cap)
        begin
            clear_now = 1'b0;
        end
        else if (ctrl1_reg.clear_source_select)
        begin
            clear_now = match_a;
        end
        else
        begin
            clear_now = match_p;
        end
    end

    always_comb
    begin
        cnt_next = cnt_reg;
        if (run_rise)
        begin
            cnt_next = STM_CNT_RST;
        end
        else if (clear_now)
        begin
            cnt_next = STM_CNT_RST;
        end
        else if (tick)
        begin
            cnt_next = cnt_inc;
        end
    end

    // Duty at or above the period gives full duty; P at zero stands for 65536
    wire logic [16:0] duty_val = p_is_period ? {1'b0, cmpa_reg}
        : ((cmpp_reg == STM_CMPP_WRAP) ? 17'h10000 : {1'b0, cmpp_reg, 8'h00});
    // Compared with the count being loaded, so the pin has no lag behind the counter
    wire logic pwm_active = ({1'b0, cnt_next} < duty_val);

    always_comb
    begin
        sp_next = sp_reg;
        case (sp_reg)
            STM_SP_IDLE:
            begin
                if (run_rise)
                begin
                    sp_next = STM_SP_ACTIVE;
                end
            end
            STM_SP_ACTIVE:
            begin
                if (!run || match_a)
                begin
                    sp_next = STM_SP_IDLE;
                end
            end
            default:
            begin
                sp_next = STM_SP_IDLE;
            end
        endcase
    end

    always_comb
    begin
        out_next = out_reg;
        if (is_cmp)
        begin
            if (run_rise)
            begin
                out_next = oc;
            end
            else if (match_a)
            begin
                case (pf)
                    STM_PF_1: out_next = 1'b0;
                    STM_PF_2: out_next = 1'b1;
                    STM_PF_3: out_next = !out_reg;
                    default: out_next = out_reg;
                endcase
            end
        end
        else if (is_pwm)
        begin
            case (pf)
                STM_PF_0: out_next = !oc;
                STM_PF_1: out_next = oc;
                STM_PF_2: out_next = (run && pwm_active) ? oc : !oc;
                default: out_next = (sp_next == STM_SP_ACTIVE) ? oc : !oc;
            endcase
        end
    end

    // Capture edge select on the synchronised pin
    wire logic cap_stable = (cap_sync_reg[1] == cap_sync_reg[2]);
    wire logic cap_new = cap_sync_reg[2];
    wire logic cap_rise = cap_stable && cap_new && !cap_level_reg;
    wire logic cap_fall = cap_stable && !cap_new && cap_level_reg;
    logic cap_hit;
    always_comb
    begin
        case (pf)
            STM_PF_0: cap_hit = cap_rise;
            STM_PF_1: cap_hit = cap_fall;
            STM_PF_2: cap_hit = cap_rise || cap_fall;
            default: cap_hit = 1'b0;
        endcase
    end
    wire logic cap_fire = run && is_cap && cap_hit;

    logic [7:0] rbyte;
    always_comb
    begin
        rbyte = 8'h00;
        if (sel_addr(addr, STM_OFF_CTRL0)) rbyte = ctrl0_reg & STM_CTRL0_MASK;
        else if (sel_addr(addr, STM_OFF_CTRL1)) rbyte = ctrl1_reg;
        else if (sel_addr(addr, STM_OFF_CNT_LO)) rbyte = buf_reg;
        else if (sel_addr(addr, STM_OFF_CNT_HI)) rbyte = cnt_reg[15:8];
        else if (sel_addr(addr, STM_OFF_CMPA_LO)) rbyte = buf_reg;
        else if (sel_addr(addr, STM_OFF_CMPA_HI)) rbyte = cmpa_reg[15:8];
        else if (sel_addr(addr, STM_OFF_CMPP)) rbyte = cmpp_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl0_reg <= STM_CTRL0_RST;
            ctrl1_reg <= STM_CTRL1_RST;
            cmpa_reg <= STM_CMPA_RST;
            cmpp_reg <= STM_CMPP_RST;
            buf_reg <= 8'h00;
        end
        else if (wr)
        begin
            if (sel_addr(addr, STM_OFF_CTRL0)) ctrl0_reg <= wbyte & STM_CTRL0_MASK;
            if (sel_addr(addr, STM_OFF_CTRL1)) ctrl1_reg <= wbyte;
            if (sel_addr(addr, STM_OFF_CMPA_LO)) buf_reg <= wbyte;
            if (sel_addr(addr, STM_OFF_CMPA_HI)) cmpa_reg <= {wbyte, buf_reg};
            if (sel_addr(addr, STM_OFF_CMPP)) cmpp_reg <= wbyte;
        end
        else if (rd)
        begin
            // High-byte read snapshots the low byte in its access cycle, one cycle after the high byte is latched in setup
            if (sel_addr(addr, STM_OFF_CNT_HI)) buf_reg <= cnt_reg[7:0];
            if (sel_addr(addr, STM_OFF_CMPA_HI)) buf_reg <= cmpa_reg[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_reg <= STM_CNT_RST;
            run_d_reg <= 1'b0;
            out_reg <= 1'b0;
            sp_reg <= STM_SP_IDLE;
            cap_sync_reg <= 3'h0;
            cap_level_reg <= 1'b0;
            capture_value <= 16'h0000;
            capture_event <= 1'b0;
            match_a_event <= 1'b0;
            match_p_event <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            cnt_reg <= cnt_next;
            run_d_reg <= run;
            out_reg <= out_next;
            sp_reg <= sp_next;
            cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
            if (cap_stable)
            begin
                cap_level_reg <= cap_new;
            end
            capture_event <= cap_fire;
            if (cap_fire)
            begin
                capture_value <= cnt_reg;
            end
            match_a_event <= match_a && !is_cap;
            match_p_event <= match_p && !is_cap && !(!is_pwm && ctrl1_reg.clear_source_select);
            // Latched in the setup cycle, so read data stands through the access
            if (setup)
            begin
                rdata_reg <= {24'h000000, rbyte};
            end
        end
    end

    // Invert applies last; in timer/counter mode the pin is released
    assign timer_output_pin = is_tc ? 1'b0 : (out_reg ^ ctrl1_reg.output_invert);
    assign timer_output_oe = !is_tc;
    assign apb_rsp.prdata = rdata_reg;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = acc && !hit;

    // Steps that the properties below are built from
    sequence s_pulse_start;
        run_rise && is_pwm && (pf == STM_PF_3);
    endsequence

    sequence s_cmpa_high_write;
        wr && sel_addr(addr, STM_OFF_CMPA_HI);
    endsequence

    sequence s_cmp_clear_on_a;
        tick && !run_rise && !is_pwm && !is_cap && ctrl1_reg.clear_source_select;
    endsequence

    AST_RUN_RISE_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
        run_rise |=> (cnt_reg == STM_CNT_RST))
        else $error("counter not zero after start");
    AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
        (!run && !run_rise) |=> $stable(cnt_reg))
        else $error("counter moved while off");
    AST_CMP_INIT: assert property (@(posedge clk) disable iff (!rst_b)
        (run_rise && is_cmp) |=> (out_reg == $past(oc)))
        else $error("output not at initial level");
    AST_PULSE_LEAD: assert property (@(posedge clk) disable iff (!rst_b)
        s_pulse_start |=> (out_reg == $past(oc)))
        else $error("pulse leading edge missing");
    AST_PULSE_TRAIL: assert property (@(posedge clk) disable iff (!rst_b)
        (is_pwm && (pf == STM_PF_3) && (sp_reg == STM_SP_ACTIVE) && match_a && !run_rise)
        |=> (out_reg == !$past(oc)))
        else $error("pulse trailing edge missing");
    AST_PWM_FORCE: assert property (@(posedge clk) disable iff (!rst_b)
        (is_pwm && (pf == STM_PF_0)) |=> (out_reg == !$past(oc)))
        else $error("forced inactive level wrong");
    AST_CMP_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
        (is_cmp && !run_rise && match_a && (pf == STM_PF_3))
        |=> (out_reg != $past(out_reg)))
        else $error("toggle missing");
    AST_INVERT: assert property (@(posedge clk) disable iff (!rst_b)
        !is_tc |-> (timer_output_pin == (out_reg ^ ctrl1_reg.output_invert)))
        else $error("polarity wrong");
    AST_TC_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
        is_tc |-> (!timer_output_oe && !timer_output_pin))
        else $error("pin driven in timer/counter mode");
    AST_CLEAR_ON_A: assert property (@(posedge clk) disable iff (!rst_b)
        s_cmp_clear_on_a ##0 match_a |=> (cnt_reg == STM_CNT_RST))
        else $error("counter not cleared on A match");
    AST_CLEAR_ON_P: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && !run_rise && !is_pwm && !is_cap && !ctrl1_reg.clear_source_select && match_p)
        |=> (cnt_reg == STM_CNT_RST))
        else $error("counter not cleared on P match");
    AST_CTRL0_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && sel_addr(addr, STM_OFF_CTRL0)) |-> (apb_rsp.prdata[2:0] == 3'h0))
        else $error("unimplemented bits nonzero");
    AST_HI_READ_BUF: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && sel_addr(addr, STM_OFF_CNT_HI)) |=> (buf_reg == $past(cnt_reg[7:0])))
        else $error("low byte not captured");
    AST_CMPA_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        s_cmpa_high_write |=> (cmpa_reg == {$past(wbyte), $past(buf_reg)}))
        else $error("compare A pair not loaded");
    AST_CAP_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
        (run && is_cap && (pf == STM_PF_0) && cap_rise)
        |=> (capture_event && (capture_value == $past(cnt_reg))))
        else $error("rising edge not captured");
    AST_CAP_NOCLR: assert property (@(posedge clk) disable iff (!rst_b)
        (is_cap && tick && !run_rise && (cnt_reg != STM_CNT_MAX))
        |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
        else $error("capture mode cleared counter");
endmodule : stm_timer

/* sim/stm_timer_tb_top.sv */
`timescale 1ns/1ps
module stm_timer_tb_top;
    import stm_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    stm_apb_req_t req = '0;
    stm_apb_rsp_t rsp;
    logic ct = 1'b0;
    logic cap_pin = 1'b0;
    logic pin, oe, cap_ev, ma, mp;
    logic [15:0] cap_val;
    logic [31:0] rdata;
    logic [15:0] cv;
    int error_cnt = 0;
    int compares = 0;
    int cap_n = 0;
    int a_n = 0;
    int p_n = 0;

    always #25 clk = ~clk;

    stm_timer i_stm_timer (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
        .count_tick(ct), .capture_input_pin(cap_pin), .timer_output_pin(pin),
        .timer_output_oe(oe), .capture_value(cap_val), .capture_event(cap_ev),
        .match_a_event(ma), .match_p_event(mp));

    // Event pulses last one cycle, so they are tallied at every edge
    always @(posedge clk)
    begin
        if (cap_ev === 1'b1) cap_n <= cap_n + 1;
        if (ma === 1'b1) a_n <= a_n + 1;
        if (mp === 1'b1) p_n <= p_n + 1;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            $display("[FAIL] pready expected 1 seen timeout");
        end
        rdata = rsp.prdata;
        chk("pslverr", (a > STM_OFF_CMPP) ? 32'h1 : 32'h0, {31'h0, rsp.pslverr});
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [11:0] a, input string name, input logic [7:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, {24'h0, exp}, rdata);
    endtask : rd

    // High byte first so the low byte comes from the shared buffer
    task automatic rd_cnt(input logic [15:0] exp);
        rd(STM_OFF_CNT_HI, "cnt_hi", exp[15:8]);
        rd(STM_OFF_CNT_LO, "cnt_lo", exp[7:0]);
    endtask : rd_cnt

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk) ct <= 1'b1;
            @(posedge clk) ct <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : tick

    // Mode and pin function are only changed with the timer off
    task automatic restart(input logic [7:0] c1);
        wr(STM_OFF_CTRL0, 8'h00);
        wr(STM_OFF_CTRL1, c1);
        wr(STM_OFF_CTRL0, 8'h08);
        repeat (3) @(posedge clk);
    endtask : restart

    task automatic set_ab(input logic [15:0] a, input logic [7:0] p);
        wr(STM_OFF_CMPA_LO, a[7:0]);
        wr(STM_OFF_CMPA_HI, a[15:8]);
        wr(STM_OFF_CMPP, p);
    endtask : set_ab

    task automatic t_regs;
        rd(STM_OFF_CTRL0, "ctrl0", 8'h00);
        rd(STM_OFF_CTRL1, "ctrl1", 8'h00);
        rd_cnt(16'h0000);
        rd(STM_OFF_CMPA_HI, "a_hi", 8'h00);
        rd(STM_OFF_CMPA_LO, "a_lo", 8'h00);
        rd(STM_OFF_CMPP, "p", 8'h00);
        wr(STM_OFF_CTRL0, 8'hff);
        rd(STM_OFF_CTRL0, "ctrl0", 8'hf8);
        wr(STM_OFF_CNT_LO, 8'h5a);
        wr(STM_OFF_CNT_HI, 8'ha5);
        rd_cnt(16'h0000);
        wr(STM_OFF_CTRL0, 8'h00);
        apb(12'h01c, 1'b1, 32'h0000_00ff);
        set_ab(16'h1234, 8'h00);
        rd(STM_OFF_CMPA_HI, "a_hi", 8'h12);
        rd(STM_OFF_CMPA_LO, "a_lo", 8'h34);
    endtask : t_regs

    task automatic t_count;
        set_ab(16'h0000, 8'h00);
        restart(8'hcc);
        chk("oe_tc", 32'h0, {31'h0, oe});
        chk("pin_tc", 32'h0, {31'h0, pin});
        tick(5);
        rd_cnt(16'h0005);
        wr(STM_OFF_CTRL0, 8'h00);
        tick(3);
        rd_cnt(16'h0005);
        wr(STM_OFF_CTRL0, 8'h08);
        repeat (3) @(posedge clk);
        rd_cnt(16'h0000);
    endtask : t_count

    task automatic t_compare;
        int a0, p0;
        set_ab(16'h0003, 8'h01);
        restart(8'h30);
        a0 = a_n;
        p0 = p_n;
        tick(5);
        rd_cnt(16'h0005);
        tick(251);
        rd_cnt(16'h0000);
        chk("p_matches", p0 + 1, p_n);
        chk("pin_toggle", 32'h1, {31'h0, pin});
        chk("a_matches", a0 + 1, a_n);
        restart(8'h31);
        chk("pin_init", 32'h0, {31'h0, pin});
        tick(3);
        rd_cnt(16'h0000);
        chk("pin_toggle", 32'h1, {31'h0, pin});
        tick(3);
        chk("pin_toggle", 32'h0, {31'h0, pin});
        restart(8'h29);
        chk("pin_init", 32'h1, {31'h0, pin});
        tick(3);
        chk("pin_same", 32'h1, {31'h0, pin});
        restart(8'h19);
        tick(3);
        chk("pin_low", 32'h0, {31'h0, pin});
        restart(8'h1d);
        chk("pin_inv", 32'h0, {31'h0, pin});
        restart(8'h09);
        tick(3);
        chk("pin_none", 32'h1, {31'h0, pin});
    endtask : t_compare

    task automatic t_capture;
        int c0;
        for (int pf = 0; pf < 4; pf++)
        begin
            restart({2'h1, pf[1:0], 4'h0});
            tick(4);
            c0 = cap_n;
            @(posedge clk) cap_pin <= 1'b1;
            repeat (8) @(posedge clk);
            chk("cap_rise", c0 + ((pf == 0 || pf == 2) ? 1 : 0), cap_n);
            if (pf == 0) chk("cap_value", 32'h4, {16'h0, cap_val});
            c0 = cap_n;
            @(posedge clk) cap_pin <= 1'b0;
            repeat (8) @(posedge clk);
            chk("cap_fall", c0 + ((pf == 1 || pf == 2) ? 1 : 0), cap_n);
        end
    endtask : t_capture

    // Active samples over a whole period; a fixed pin lag does not change the sum
    task automatic duty(input int n, input int exp);
        int h;
        h = 0;
        tick(n);
        repeat (n)
        begin
            tick(1);
            h += (pin === 1'b1) ? 1 : 0;
        end
        chk("pwm_active", exp, h);
    endtask : duty

    task automatic t_pwm;
        set_ab(16'h0040, 8'h01);
        restart(8'ha9);
        duty(256, 64);
        set_ab(16'h0200, 8'h01);
        restart(8'haa);
        duty(512, 256);
        restart(8'h88);
        chk("pwm_off", 32'h0, {31'h0, pin});
        restart(8'h98);
        chk("pwm_on", 32'h1, {31'h0, pin});
        set_ab(16'h0003, 8'h00);
        restart(8'hb8);
        chk("pulse_lead", 32'h1, {31'h0, pin});
        tick(4);
        chk("pulse_trail", 32'h0, {31'h0, pin});
    endtask : t_pwm

    task automatic wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_count();
        t_compare();
        t_capture();
        t_pwm();
        wrap_up();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        wrap_up();
    end
endmodule : stm_timer_tb_top
